// File: dv/asr_host_model.sv
// SPI host model that drives chip select, serial clock and data in.
// Assumes the bench resolves the device's output line and feeds it to dout.
`timescale 1ns/1ps
`default_nettype none

module asr_host_model (
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end

	// Odd offset keeps the serial clock out of step with the system clock
	task select(input logic v);
		#7 cs_n = v;
		#400;
	endtask : select

	// ==================================================
	// Frame: data changes on the rise and is read just before the fall
	task frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = '0;
		#3;
		for (int i = 15; i > 15 - nbits; i--) begin
			sclk = 1'b1;
			din = tx[i];
			#199 rx[i] = dout;
			#1 sclk = 1'b0;
			#200;
		end
		din = ~din;
	endtask : frame
endmodule : asr_host_model

`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the converter serial port and register bank.
// Assumes the host model and a shortened serial timeout parameter.
`timescale 1ns/1ps
`default_nettype none

module tb_top import asr_pkg::*; ;
	localparam int TMO = 200;
	localparam int EARLY = CLK_HZ / 3300 - LEAD_CYC;
	logic clk, rst, res_valid, conv_busy;
	logic [RES_BITS-1:0] res_data;
	logic dout_last = 1'b0;
	logic cs_n, sclk, din, dout, line_o, oe_n, pu_en, res_ready, ss_pulse;
	asr_conv_ctl_t conv_ctl;
	int n_mismatch = 0;
	int tests_run = 0;
	int n_ss = 0;
	logic [31:0] seed = 32'h0000002D;
	logic [15:0] cfg, rx;
	logic [11:0] prev;
	logic [1:0] bad [3] = '{2'h0, 2'h2, 2'h3};

	asr_host_model host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
	asr_spi_regs #(.TIMEOUT_CYCLES(TMO)) dut (.clk(clk), .rst(rst), .cs_n_pin(cs_n),
		.sclk_pin(sclk), .din_pin(din), .serial_out_ready_line_o(line_o), .serial_out_ready_line_oe_n(oe_n),
		.serial_out_pullup_en(pu_en), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
		.conv_busy(conv_busy), .single_shot_start(ss_pulse), .conv_ctl(conv_ctl));

	// Floating wire shows the inverse of its last driven level
	always @(posedge clk) if (oe_n === 1'b0) dout_last <= line_o;
	assign dout = (oe_n === 1'b0) ? line_o : ((pu_en === 1'b1) ? 1'b1 : ~dout_last);
	always @(posedge clk) if (ss_pulse === 1'b1) n_ss <= n_ss + 1;

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic asr_conv_ctl_t exp_ctl(input logic [15:0] c);
		asr_conv_ctl_t e;
		e.negative_is_ground = c[14];
		e.positive_input_node = c[14] ? c[13:12] : (c[13] ? c[13:12] - 2'h1 : 2'h0);
		e.negative_input_node = c[14] ? 2'h0 : ((c[13:12] == 2'h0) ? 2'h1 : 2'h3);
		e.gain_range_select = (c[11:9] > 3'h4) ? 3'h5 : c[11:9];
		e.continuous_mode = ~c[8];
		e.conv_rate_select = c[7:5];
		e.temp_sense_select = c[4];
		return e;
	endfunction : exp_ctl

	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	task tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick

	task push(input logic [11:0] d, input logic full);
		@(posedge clk);
		#2 res_valid = 1'b1;
		res_data = d;
		if (full) begin
			tick(3);
			check("res_ready full", {15'h0, res_ready}, 16'h0000);
		end
		// Ready only moves on an edge, so looking between edges shows what the next edge takes
		while (res_ready !== 1'b1) begin
			tick(1);
		end
		tick(1);
		res_valid = 1'b0;
		res_data = ~d;
	endtask : push

	task stop_test();
		$display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	// Whole run takes about 0.5 ms; four times that means a hang
	initial begin
		#2_000_000;
		n_mismatch++;
		stop_test();
	end

	// ==================================================
	// Scenarios
	initial begin
		rst = 1'b1;
		res_valid = 1'b0;
		res_data = '0;
		conv_busy = 1'b0;
		tick(16);
		rst = 1'b0;
		tick(4);
		check("ctl reset", {3'h0, conv_ctl}, {3'h0, exp_ctl(CFG_RESET)});
		check("oe_n deselected", {15'h0, oe_n}, 16'h0001);
		check("pull-up default", {15'h0, pu_en}, 16'h0001);
		host.select(1'b0);
		check("idle empty", {15'h0, dout}, 16'h0001);
		host.frame(16'h858B, 16, rx);
		check("first read", rx, RES_RESET);
		tick(8);
		conv_busy = 1'b1;
		host.frame(16'h858B, 16, rx);
		tick(8);
		check("single-shot pulses", 16'(n_ss), 16'h0001);
		conv_busy = 1'b0;
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			cfg = {1'b0, 3'(i), 3'(i), seed[8], 3'(i), seed[4:3], 3'h3};
			prev = seed[27:16];
			push(prev, 1'b0);
			tick(4);
			check("ready low", {15'h0, dout}, 16'h0000);
			host.frame(cfg, 16, rx);
			check("result word", rx, {prev, 4'h0});
			tick(8);
			check("ctl decode", {3'h0, conv_ctl}, {3'h0, exp_ctl(cfg)});
			check("line after read", {15'h0, dout}, 16'h0001);
			host.select(1'b1);
			check("pull-up select", {15'h0, pu_en}, {15'h0, cfg[3]});
			check("released", {15'h0, oe_n}, 16'h0001);
			host.select(1'b0);
		end
		for (int k = 0; k < 3; k++) begin
			seed = xs(seed);
			host.frame({1'b1, seed[14:3], bad[k], 1'b1}, 16, rx);
			tick(8);
			check("bad key", {3'h0, conv_ctl}, {3'h0, exp_ctl(cfg)});
		end
		check("bad key start", 16'(n_ss), 16'h0001);
		fork
			host.frame(cfg, 16, rx);
			begin
				tick(20);
				push(12'hA5C, 1'b0);
				push(12'h3F1, 1'b0);
				push(12'h801, 1'b1);
			end
		join
		check("locked word", rx, {prev, 4'h0});
		tick(8);
		host.frame(cfg, 16, rx);
		check("latest word", rx, {12'h801, 4'h0});
		for (int j = 0; j < 2; j++) begin
			cfg = 16'h3C43 ^ {11'h0, j[0], 4'h0};
			host.frame(16'hFFFF, 8, rx);
			if (j == 0) begin
				tick(TMO + 50);
			end else begin
				host.select(1'b1);
				host.select(1'b0);
			end
			host.frame(cfg, 16, rx);
			tick(8);
			check("ctl after abort", {3'h0, conv_ctl}, {3'h0, exp_ctl(cfg)});
		end
		// Start bit set while continuous: must not start a conversion
		host.frame(16'h84CB, 16, rx);
		push(12'h123, 1'b0);
		for (int w = 0; w < 20 && dout !== 1'b0; w++) begin
			tick(1);
		end
		tick(EARLY - 50);
		check("held before lead", {15'h0, dout}, 16'h0000);
		tick(100);
		check("early return", {15'h0, dout}, 16'h0001);
		check("no start in continuous", 16'(n_ss), 16'h0001);
		stop_test();
	end
endmodule : tb_top

`default_nettype wire

// File: rtl/asr_buf2.sv
// Small valid/ready buffer between converter results and the result register.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
`default_nettype none

module asr_buf2 import asr_pkg::*; #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
	logic [CW-1:0] count_ff, nxt_count;
	logic push, pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : ptr_inc

	assign in_ready = (count_ff != CW'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data = mem[rd_ptr_ff];

	always_comb begin
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		nxt_wr_ptr = push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
		nxt_rd_ptr = pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
		nxt_count = count_ff;
		if (push && !pop) begin
			nxt_count = CW'(count_ff + 1'b1);
		end else if (pop && !push) begin
			nxt_count = CW'(count_ff - 1'b1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
		end
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

endmodule : asr_buf2

`default_nettype wire

// File: rtl/asr_spi_regs.sv
// Serial port and two-register bank of a small converter device.
// Assumes async pins (chip select, serial clock, data in) and converter logic on clk.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Chip select high resets port, releases line
// - Select falling shows ready level at once
// - Result locked in shifter for whole frame
// - Clock low for timeout resets port
// - Data in sampled on clock falling edge
// - Next output bit on clock rising edge
// - Line pulled low when result ready
// - Unread result, continuous mode: line high before next
// - Deselected line: pull-up or high impedance
// - Registers reached only through serial port
// - Result left justified, low nibble zero
// - Result reads zero until first conversion
// - Configuration layout and reset default
// - Single-shot start only in power-down, reads zero
// - Input select chooses eight input pairings
// - Gain codes five to seven alias smallest
// - Write only when key equals one
// - Mode bit: continuous or power-down
// - Rate field selects conversion rate
module asr_spi_regs import asr_pkg::*; #(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
	parameter int BUF_DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n_pin,
	input wire logic sclk_pin,
	input wire logic din_pin,
	output logic serial_out_ready_line_o,
	output logic serial_out_ready_line_oe_n,
	output logic serial_out_pullup_en,
	input wire logic res_valid,
	output logic res_ready,
	input wire logic [RES_BITS-1:0] res_data,
	input wire logic conv_busy,
	output logic single_shot_start,
	output asr_conv_ctl_t conv_ctl
);
	localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

	typedef enum logic {ST_IDLE, ST_SHIFT} asr_state_t;

	// ==================================================
	// Pin synchronisers
	logic cs_meta_ff, cs_s_ff, sclk_meta_ff, sclk_s_ff, sclk_d_ff, din_meta_ff, din_s_ff;
	logic sclk_rise, sclk_fall;

	always_ff @(posedge clk) begin
		if (rst) begin
			cs_meta_ff <= 1'b1;
			cs_s_ff <= 1'b1;
			sclk_meta_ff <= 1'b0;
			sclk_s_ff <= 1'b0;
			sclk_d_ff <= 1'b0;
			din_meta_ff <= 1'b0;
			din_s_ff <= 1'b0;
		end else begin
			cs_meta_ff <= cs_n_pin;
			cs_s_ff <= cs_meta_ff;
			sclk_meta_ff <= sclk_pin;
			sclk_s_ff <= sclk_meta_ff;
			sclk_d_ff <= sclk_s_ff;
			din_meta_ff <= din_pin;
			din_s_ff <= din_meta_ff;
		end
	end

	assign sclk_rise = sclk_s_ff & ~sclk_d_ff;
	assign sclk_fall = ~sclk_s_ff & sclk_d_ff;

	// ==================================================
	// Result buffer: drained only between frames, so a frame never sees a new word
	logic buf_valid, buf_ready;
	logic [RES_BITS-1:0] buf_data;
	logic res_load;

	asr_buf2 #(
		.WIDTH(RES_BITS),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk(clk),
		.rst(rst),
		.in_valid(res_valid),
		.in_ready(res_ready),
		.in_data(res_data),
		.out_valid(buf_valid),
		.out_ready(buf_ready),
		.out_data(buf_data)
	);

	// ==================================================
	// Serial clock timeout
	logic [TO_W-1:0] to_cnt_ff, nxt_to_cnt;
	logic timeout_hit;

	always_comb begin
		timeout_hit = (to_cnt_ff == TO_W'(TIMEOUT_CYCLES - 1)) & ~sclk_s_ff & ~cs_s_ff;
		if (sclk_s_ff || cs_s_ff) begin
			nxt_to_cnt = '0;
		end else if (to_cnt_ff != TO_W'(TIMEOUT_CYCLES)) begin
			nxt_to_cnt = TO_W'(to_cnt_ff + 1'b1);
		end else begin
			nxt_to_cnt = to_cnt_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			to_cnt_ff <= '0;
		end else begin
			to_cnt_ff <= nxt_to_cnt;
		end
	end

	// ==================================================
	// Frame engine
	asr_state_t state_ff, nxt_state;
	logic [FRAME_BITS-1:0] tx_ff, nxt_tx, rx_ff, nxt_rx, result_ff, nxt_result;
	logic [4:0] bit_cnt_ff, nxt_bit_cnt;
	logic frame_done;
	logic [FRAME_BITS-1:0] frame_word;

	always_comb begin
		nxt_state = state_ff;
		nxt_tx = tx_ff;
		nxt_rx = rx_ff;
		nxt_bit_cnt = bit_cnt_ff;
		frame_done = 1'b0;
		frame_word = {rx_ff[FRAME_BITS-2:0], din_s_ff};
		buf_ready = (state_ff == ST_IDLE) & ~cs_s_ff & ~sclk_rise;
		if (cs_s_ff) begin
			buf_ready = 1'b1;
		end
		res_load = buf_valid & buf_ready;
		nxt_result = res_load ? {buf_data, RES_PAD_BITS'(0)} : result_ff;
		if (cs_s_ff || timeout_hit) begin
			nxt_state = ST_IDLE;
			nxt_bit_cnt = '0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (sclk_rise) begin
						nxt_state = ST_SHIFT;
						nxt_tx = result_ff;
						nxt_bit_cnt = '0;
					end
				end
				ST_SHIFT: begin
					if (sclk_rise && bit_cnt_ff != 5'h0) begin
						nxt_tx = {tx_ff[FRAME_BITS-2:0], 1'b0};
					end
					if (sclk_fall) begin
						nxt_rx = frame_word;
						nxt_bit_cnt = 5'(bit_cnt_ff + 1'b1);
						if (bit_cnt_ff == 5'(FRAME_BITS - 1)) begin
							frame_done = 1'b1;
							nxt_state = ST_IDLE;
							nxt_bit_cnt = '0;
						end
					end
				end
				default: begin
					nxt_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			tx_ff <= '0;
			rx_ff <= '0;
			bit_cnt_ff <= '0;
			result_ff <= RES_RESET;
		end else begin
			state_ff <= nxt_state;
			tx_ff <= nxt_tx;
			rx_ff <= nxt_rx;
			bit_cnt_ff <= nxt_bit_cnt;
			result_ff <= nxt_result;
		end
	end

	// ==================================================
	// Configuration register, reached only by a completed frame
	asr_cfg_t cfg_ff, nxt_cfg, wr_cfg;
	logic nxt_ss;
	logic key_ok;

	always_comb begin
		wr_cfg = asr_cfg_t'(frame_word);
		key_ok = frame_done & (wr_cfg.write_valid_key == KEY_VALID);
		nxt_cfg = cfg_ff;
		if (key_ok) begin
			nxt_cfg = wr_cfg;
			nxt_cfg.single_shot = 1'b0;
			nxt_cfg.spare_one = 1'b1;
		end
		nxt_ss = key_ok & wr_cfg.single_shot & cfg_ff.power_down & ~conv_busy;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_ff <= asr_cfg_t'(CFG_RESET);
			single_shot_start <= 1'b0;
			conv_ctl <= asr_ctl_decode(asr_cfg_t'(CFG_RESET));
		end else begin
			cfg_ff <= nxt_cfg;
			single_shot_start <= nxt_ss;
			conv_ctl <= asr_ctl_decode(nxt_cfg);
		end
	end

	// ==================================================
	// Ready flag, early return in continuous mode, pin drive
	logic unread_ff, nxt_unread;
	logic [PER_W-1:0] per_cnt_ff, nxt_per_cnt;
	logic lead_hit;
	logic nxt_line, nxt_oe_n, nxt_pullup;

	always_comb begin
		lead_hit = ~cfg_ff.power_down & unread_ff
			& (per_cnt_ff == PER_W'(asr_period_cyc(cfg_ff.conv_rate_select) - LEAD_CYC));
		nxt_per_cnt = res_load ? '0 : ((per_cnt_ff == '1) ? per_cnt_ff : PER_W'(per_cnt_ff + 1'b1));
		// New result wins over a clear in the same cycle
		if (res_load) begin
			nxt_unread = 1'b1;
		end else if (frame_done || lead_hit) begin
			nxt_unread = 1'b0;
		end else begin
			nxt_unread = unread_ff;
		end
		nxt_oe_n = cs_s_ff;
		nxt_pullup = cs_s_ff & cfg_ff.pullup_enable;
		if (cs_s_ff) begin
			nxt_line = 1'b1;
		end else if (nxt_state == ST_SHIFT) begin
			nxt_line = nxt_tx[FRAME_BITS-1];
		end else begin
			nxt_line = ~nxt_unread;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			unread_ff <= 1'b0;
			per_cnt_ff <= '0;
			serial_out_ready_line_o <= 1'b1;
			serial_out_ready_line_oe_n <= 1'b1;
			serial_out_pullup_en <= 1'b1;
		end else begin
			unread_ff <= nxt_unread;
			per_cnt_ff <= nxt_per_cnt;
			serial_out_ready_line_o <= nxt_line;
			serial_out_ready_line_oe_n <= nxt_oe_n;
			serial_out_pullup_en <= nxt_pullup;
		end
	end

	// ==================================================
	// Checks
	a_desel_release: assert property (@(posedge clk) disable iff (rst)
		cs_s_ff |=> (serial_out_ready_line_oe_n && state_ff == ST_IDLE))
		else $error("line not released while deselected");
	a_ready_level: assert property (@(posedge clk) disable iff (rst)
		(!cs_s_ff && nxt_state == ST_IDLE) |=> (serial_out_ready_line_o == !unread_ff && !serial_out_ready_line_oe_n))
		else $error("idle line does not show ready level");
	a_frame_locked: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_SHIFT && !cs_s_ff) |=> $stable(result_ff))
		else $error("result changed during a frame");
	a_timeout_idle: assert property (@(posedge clk) disable iff (rst)
		timeout_hit |=> (state_ff == ST_IDLE && bit_cnt_ff == 5'h0))
		else $error("timeout did not reset the port");
	a_fall_sample: assert property (@(posedge clk) disable iff (rst)
		(sclk_fall && state_ff == ST_SHIFT && !cs_s_ff && !timeout_hit) |=> (rx_ff[0] == $past(din_s_ff)))
		else $error("data in not sampled on falling edge");
	a_rise_shift: assert property (@(posedge clk) disable iff (rst)
		(sclk_rise && state_ff == ST_SHIFT && bit_cnt_ff != 5'h0 && !cs_s_ff && !timeout_hit)
		|=> (serial_out_ready_line_o == $past(tx_ff[FRAME_BITS-2])))
		else $error("output bit not advanced on rising edge");
	a_lead_return: assert property (@(posedge clk) disable iff (rst)
		(lead_hit && !res_load) |=> !unread_ff)
		else $error("unread flag not dropped ahead of next result");
	a_result_pad: assert property (@(posedge clk) disable iff (rst)
		result_ff[RES_PAD_BITS-1:0] == 4'h0)
		else $error("result low nibble not zero");
	a_cfg_fixed: assert property (@(posedge clk) disable iff (rst)
		!cfg_ff.single_shot && cfg_ff.spare_one)
		else $error("fixed configuration bits wrong");
	a_key_guard: assert property (@(posedge clk) disable iff (rst)
		(frame_done && wr_cfg.write_valid_key != KEY_VALID) |=> ($stable(cfg_ff) && !single_shot_start))
		else $error("configuration changed without valid key");
	a_ss_once: assert property (@(posedge clk) disable iff (rst)
		single_shot_start |-> ($past(cfg_ff.power_down) && !$past(conv_busy)) ##1 !single_shot_start)
		else $error("single-shot start out of place");

endmodule : asr_spi_regs

`default_nettype wire

// File: shared/asr_pkg.sv
// Constants, types and helpers for the converter serial port and register bank.
// Assumes a single 20 MHz system clock; pins arrive asynchronously.
package asr_pkg;

	// ==================================================
	// Clock and timing
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int TIMEOUT_MS = 28;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int LEAD_NS = 8000;
	localparam int LEAD_CYC = LEAD_NS / CLK_PERIOD_NS;
	localparam int PER_W = 18;

	// ==================================================
	// Frame and register layout
	localparam int FRAME_BITS = 16;
	localparam int RES_BITS = 12;
	localparam int RES_PAD_BITS = 4;
	localparam logic [15:0] RES_RESET = 16'h0000;
	localparam logic [15:0] CFG_RESET = 16'h058B;
	localparam logic [1:0] KEY_VALID = 2'h1;
	localparam logic [2:0] GAIN_MIN_CODE = 3'h5;
	localparam int RATE_SPS [0:7] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};

	typedef struct packed {
		logic single_shot;
		logic [2:0] input_pair_select;
		logic [2:0] gain_range_select;
		logic power_down;
		logic [2:0] conv_rate_select;
		logic temp_sense_select;
		logic pullup_enable;
		logic [1:0] write_valid_key;
		logic spare_one;
	} asr_cfg_t;

	typedef struct packed {
		logic [1:0] positive_input_node;
		logic [1:0] negative_input_node;
		logic negative_is_ground;
		logic [2:0] gain_range_select;
		logic continuous_mode;
		logic [2:0] conv_rate_select;
		logic temp_sense_select;
	} asr_conv_ctl_t;

	// ==================================================
	// Helpers
	function automatic int asr_period_cyc(input logic [2:0] code);
		return CLK_HZ / RATE_SPS[code];
	endfunction : asr_period_cyc

	function automatic asr_conv_ctl_t asr_ctl_decode(input asr_cfg_t cfg);
		asr_conv_ctl_t c;
		c = '0;
		if (cfg.input_pair_select[2]) begin
			c.positive_input_node = cfg.input_pair_select[1:0];
			c.negative_is_ground = 1'b1;
		end else begin
			case (cfg.input_pair_select[1:0])
				2'h0: begin
					c.negative_input_node = 2'h1;
				end
				2'h1: begin
					c.negative_input_node = 2'h3;
				end
				2'h2: begin
					c.positive_input_node = 2'h1;
					c.negative_input_node = 2'h3;
				end
				default: begin
					c.positive_input_node = 2'h2;
					c.negative_input_node = 2'h3;
				end
			endcase
		end
		// Codes above the smallest range all alias onto it
		c.gain_range_select = (cfg.gain_range_select > GAIN_MIN_CODE) ? GAIN_MIN_CODE : cfg.gain_range_select;
		c.continuous_mode = ~cfg.power_down;
		c.conv_rate_select = cfg.conv_rate_select;
		c.temp_sense_select = cfg.temp_sense_select;
		return c;
	endfunction : asr_ctl_decode

endpackage : asr_pkg
